// ===== hdl/gpmc_pkg.sv
// Package for the gauge power mode controller: modes, timing, configuration carrier.
// Assumes a 50 MHz system clock.
package gpmc_pkg;

  localparam int CLK_HZ = 50_000_000;

  // Avalon register offsets (byte addresses)
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_IDLE_LIMIT = 4'h4;
  localparam logic [3:0] ADDR_WAIT_TIME = 4'h8;
  localparam logic [3:0] ADDR_COMMAND = 4'hC;

  // Status layout in the config register read value, and the deep bit of the command register
  localparam int CFG_SLEEP_EN_BIT = 0;
  localparam int CFG_DEEP_FLAG_BIT = 1;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_CAL_BIT = 6;
  localparam int CMD_DEEP_BIT = 0;

  // Reset values
  localparam logic CFG_SLEEP_EN_RESET = 1'b0;
  localparam logic [15:0] IDLE_LIMIT_RESET = 16'h000A;
  localparam logic [15:0] WAIT_TIME_RESET = 16'h0000;

  // Timing
  localparam int STRETCH_MS = 4;
  localparam int STRETCH_CYCLES = STRETCH_MS * (CLK_HZ / 1000);
  localparam int CAL_CYCLES_DEF = 16;
  localparam int NORMAL_PERIOD_DEF = 1_000;
  localparam int SLEEP_PERIOD_DEF = 20_000;
  localparam int DEEP_PERIOD_DEF = 80_000;
  localparam int WAIT_TICK_DEF = 50_000;

  typedef enum logic [1:0] {
    GPMC_MODE_NORMAL,
    GPMC_MODE_SLEEP,
    GPMC_MODE_DEEP
  } gpmc_mode_type;

  typedef struct packed {
    logic sleep_enable;
    logic [15:0] idle_limit;
    logic [15:0] wait_time;
  } gpmc_cfg_type;

endpackage

// ===== hdl/gpmc_sync.sv
// Three-stage synchroniser with agreement filter.
// Assumes an asynchronous level input and the system clock.
`timescale 1ns/1ns
module gpmc_sync
  import gpmc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Async level in, filtered level out
  input wire logic i_async,
  output logic o_level
);

  logic stage1;
  logic stage2;
  logic stage3;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      o_level <= 1'b0;
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        o_level <= stage3;
      end
    end
  end

endmodule

// ===== hdl/gpmc_top.sv
// Power mode controller: normal, sleep and deep idle sequencing with Avalon-MM registers.
// Assumes a 50 MHz clock; wake and bus activity pins arrive asynchronously.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Three modes, autonomous moves, host may request
// - Normal is default; measures, updates, decides
// - Sleep only if enabled and current below limit
// - Offset calibration between qualification and sleep entry
// - Sleep measures at slower rate, idle between
// - Leave sleep on high current or wake
// - Deep idle stops oscillator, slowest measurement rate
// - Deep-idle command sets flag; wait zero enters
// - Wait nonzero counts down in sleep, then deep
// - Any serial activity leaves deep idle
// - Hold serial line low up to 4 ms
module gpmc_top
  import gpmc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYCLES_DEF,
  parameter int NORMAL_PERIOD = NORMAL_PERIOD_DEF,
  parameter int SLEEP_PERIOD = SLEEP_PERIOD_DEF,
  parameter int DEEP_PERIOD = DEEP_PERIOD_DEF,
  parameter int WAIT_TICK = WAIT_TICK_DEF,
  parameter int STRETCH = STRETCH_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Measurement inputs
  input wire logic signed [15:0] i_average_current_value,
  input wire logic i_wake_current_threshold,
  input wire logic i_serial_activity,
  // Measurement and power control
  output logic o_measure_strobe,
  output logic o_calibrate,
  output logic o_hf_osc_enable,
  output logic [1:0] o_mode,
  // Serial line stretch (open drain, low while enabled)
  output logic o_serial_hold_oe
);

  // Refuse pacing the counters cannot serve; the stretch may not pass 4 ms
  if (CAL_CYCLES < 1 || NORMAL_PERIOD < 1 || SLEEP_PERIOD <= NORMAL_PERIOD ||
      DEEP_PERIOD <= SLEEP_PERIOD || WAIT_TICK < 1 || STRETCH < 1 ||
      STRETCH > STRETCH_CYCLES) begin : g_bad_timing
    $error("gpmc_top: bad timing parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pin inputs
  logic wake_level;
  logic activity_level;
  logic activity_prev;
  gpmc_sync u_wake_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_wake_current_threshold),
    .o_level(wake_level)
  );
  gpmc_sync u_act_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_serial_activity),
    .o_level(activity_level)
  );
  wire activity_edge = activity_level & ~activity_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  gpmc_cfg_type cfg;
  logic deep_idle_flag;
  logic bus_pending;
  gpmc_mode_type mode;
  logic calibrating;

  // Write lands in the answering cycle, when the request is already pending
  function automatic logic wr_hit(input logic wr, input logic pend, input logic [3:0] addr,
                                  input logic [3:0] offs);
    wr_hit = wr & pend & (addr == offs);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  wire bus_access = (i_avs_read | i_avs_write) & ~bus_pending;
  wire wr_config = wr_hit(i_avs_write, bus_pending, i_avs_address, ADDR_CONFIG);
  wire wr_limit = wr_hit(i_avs_write, bus_pending, i_avs_address, ADDR_IDLE_LIMIT);
  wire wr_wait = wr_hit(i_avs_write, bus_pending, i_avs_address, ADDR_WAIT_TIME);
  wire wr_cmd = wr_hit(i_avs_write, bus_pending, i_avs_address, ADDR_COMMAND);
  wire deep_cmd = wr_cmd & i_avs_byteenable[0] & i_avs_writedata[CMD_DEEP_BIT];
  wire [15:0] next_limit = merge16(cfg.idle_limit, i_avs_writedata, i_avs_byteenable);
  wire [15:0] next_wait_time = merge16(cfg.wait_time, i_avs_writedata, i_avs_byteenable);

  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (i_avs_address)
      ADDR_CONFIG: begin
        next_readdata[CFG_SLEEP_EN_BIT] = cfg.sleep_enable;
        next_readdata[CFG_DEEP_FLAG_BIT] = deep_idle_flag;
        next_readdata[STAT_MODE_LSB +: 2] = mode;
        next_readdata[STAT_CAL_BIT] = calibrating;
      end
      ADDR_IDLE_LIMIT: next_readdata[15:0] = cfg.idle_limit;
      ADDR_WAIT_TIME: next_readdata[15:0] = cfg.wait_time;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access: waitrequest drops the cycle after a request appears
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_pending <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_pending <= bus_access;
      o_avs_waitrequest <= ~bus_access;
      if (bus_access) begin
        o_avs_readdata <= next_readdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg.sleep_enable <= CFG_SLEEP_EN_RESET;
      cfg.idle_limit <= IDLE_LIMIT_RESET;
      cfg.wait_time <= WAIT_TIME_RESET;
    end else begin
      if (wr_config && i_avs_byteenable[0]) begin
        cfg.sleep_enable <= i_avs_writedata[CFG_SLEEP_EN_BIT];
      end
      if (wr_limit) begin
        cfg.idle_limit <= next_limit;
      end
      if (wr_wait) begin
        cfg.wait_time <= next_wait_time;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decisions
  wire signed [16:0] avg_ext = {i_average_current_value[15], i_average_current_value};
  wire signed [16:0] limit_ext = {1'b0, cfg.idle_limit};
  wire current_low = avg_ext < limit_ext;
  wire sleep_ok = cfg.sleep_enable & current_low;
  wire sleep_break = ~sleep_ok | wake_level;
  wire wait_zero = (cfg.wait_time == 16'h0000);

  logic [31:0] cal_cnt;
  logic [31:0] meas_cnt;
  logic [31:0] tick_cnt;
  logic [15:0] wait_cnt;
  logic [31:0] stretch_cnt;
  wire wait_tick = (tick_cnt == 32'(WAIT_TICK - 1));
  wire timer_done = ~wait_zero & (wait_cnt == 16'h0000);
  wire deep_go = wait_zero ? deep_idle_flag : timer_done;

  gpmc_mode_type next_mode;
  logic next_cal;
  always_comb begin
    next_mode = mode;
    next_cal = calibrating;
    unique case (mode)
      GPMC_MODE_NORMAL: begin
        if (calibrating) begin
          if (!sleep_ok) begin
            next_cal = 1'b0;
          end else if (cal_cnt == 32'(CAL_CYCLES - 1)) begin
            next_cal = 1'b0;
            next_mode = GPMC_MODE_SLEEP;
          end
        end else if (sleep_ok) begin
          next_cal = 1'b1;
        end
      end
      GPMC_MODE_SLEEP: begin
        if (sleep_break) begin
          next_mode = GPMC_MODE_NORMAL;
        end else if (deep_go) begin
          next_mode = GPMC_MODE_DEEP;
        end
      end
      GPMC_MODE_DEEP: begin
        if (activity_edge || sleep_break) begin
          next_mode = GPMC_MODE_NORMAL;
        end
      end
      default: next_mode = GPMC_MODE_NORMAL;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode <= GPMC_MODE_NORMAL;
      calibrating <= 1'b0;
      activity_prev <= 1'b0;
    end else begin
      mode <= next_mode;
      calibrating <= next_cal;
      activity_prev <= activity_level;
    end
  end

  // Deep idle flag: command set wins over the clear on leaving deep idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      deep_idle_flag <= 1'b0;
    end else if (deep_cmd) begin
      deep_idle_flag <= 1'b1;
    end else if (mode == GPMC_MODE_DEEP && next_mode == GPMC_MODE_NORMAL) begin
      deep_idle_flag <= 1'b0;
    end
  end

  // Calibration length counter
  always_ff @(posedge i_clk) begin
    if (i_rst || !calibrating) begin
      cal_cnt <= 32'h0000_0000;
    end else begin
      cal_cnt <= cal_cnt + 32'h0000_0001;
    end
  end

  // Wait-time countdown, one step per tick while in sleep
  // A write in sleep restarts it, so a stale zero cannot fire at once
  always_ff @(posedge i_clk) begin
    if (i_rst || mode != GPMC_MODE_SLEEP) begin
      tick_cnt <= 32'h0000_0000;
      wait_cnt <= cfg.wait_time;
    end else if (wr_wait) begin
      tick_cnt <= 32'h0000_0000;
      wait_cnt <= next_wait_time;
    end else begin
      tick_cnt <= wait_tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
      if (wait_tick && wait_cnt != 16'h0000) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement pacing per mode
  wire [31:0] period = (mode == GPMC_MODE_DEEP) ? 32'(DEEP_PERIOD) :
                       (mode == GPMC_MODE_SLEEP) ? 32'(SLEEP_PERIOD) :
                       32'(NORMAL_PERIOD);
  wire meas_due = (meas_cnt >= period - 32'h0000_0001);
  wire mode_change = (next_mode != mode);

  always_ff @(posedge i_clk) begin
    if (i_rst || mode_change || meas_due) begin
      meas_cnt <= 32'h0000_0000;
    end else begin
      meas_cnt <= meas_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_measure_strobe <= 1'b0;
      o_calibrate <= 1'b0;
      o_hf_osc_enable <= 1'b1;
      o_mode <= 2'h0;
    end else begin
      o_measure_strobe <= meas_due & ~mode_change;
      o_calibrate <= next_cal;
      o_hf_osc_enable <= (next_mode != GPMC_MODE_DEEP);
      o_mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line stretch while waking from deep idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stretch_cnt <= 32'h0000_0000;
      o_serial_hold_oe <= 1'b0;
    end else if (mode == GPMC_MODE_DEEP && activity_edge) begin
      stretch_cnt <= 32'(STRETCH - 1);
      o_serial_hold_oe <= 1'b1;
    end else if (stretch_cnt != 32'h0000_0000) begin
      stretch_cnt <= stretch_cnt - 32'h0000_0001;
    end else begin
      o_serial_hold_oe <= 1'b0;
    end
  end

endmodule

// ===== test/gpmc_chk.sv
// Port checker for the power mode controller.
// Assumes it is bound into gpmc_top and sees only its ports.
`timescale 1ns/1ns
module gpmc_chk
  import gpmc_pkg::*;
#(
  parameter int NORMAL_PERIOD = 10,
  parameter int SLEEP_PERIOD = 20,
  parameter int DEEP_PERIOD = 40,
  parameter int STRETCH = 20
) (
  // Clock, reset and wake inputs
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wake_current_threshold,
  input wire logic i_serial_activity,
  // Watched outputs
  input wire logic o_measure_strobe,
  input wire logic o_calibrate,
  input wire logic o_hf_osc_enable,
  input wire logic [1:0] o_mode,
  input wire logic o_serial_hold_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [1:0] mode_q;
  int gap;
  int hold;
  int per;
  assign per = o_mode == GPMC_MODE_SLEEP ? SLEEP_PERIOD :
    o_mode == GPMC_MODE_DEEP ? DEEP_PERIOD : NORMAL_PERIOD;
  // Cycles since last strobe or mode change, and stretch length
  always_ff @(posedge i_clk) begin
    mode_q <= o_mode;
    gap <= (i_rst || o_measure_strobe || o_mode != mode_q) ? 0 : gap + 1;
    hold <= o_serial_hold_oe ? hold + 1 : 0;
  end
  //////////////////////////////
  sequence enter_sleep_s;
    o_mode == GPMC_MODE_NORMAL ##1 o_mode == GPMC_MODE_SLEEP;
  endsequence
  sequence enter_deep_s;
    o_mode != GPMC_MODE_DEEP ##1 o_mode == GPMC_MODE_DEEP;
  endsequence
  mode_legal_a: assert property (o_mode != 2'h3)
    else $error("mode code out of range");
  cal_first_a: assert property (enter_sleep_s |-> $past(o_calibrate))
    else $error("sleep entered without calibration");
  deep_from_a: assert property (enter_deep_s |-> $past(o_mode) == GPMC_MODE_SLEEP)
    else $error("deep idle entered from wrong mode");
  osc_off_a: assert property ((o_mode == GPMC_MODE_DEEP) == !o_hf_osc_enable)
    else $error("oscillator enable wrong for mode");
  wake_exit_a: assert property (o_mode == GPMC_MODE_SLEEP && i_wake_current_threshold
    |-> ##[1:8] o_mode == GPMC_MODE_NORMAL) else $error("wake did not leave sleep");
  act_exit_a: assert property ($rose(i_serial_activity) && o_mode == GPMC_MODE_DEEP
    |-> ##[1:8] o_mode == GPMC_MODE_NORMAL) else $error("activity did not leave deep idle");
  hold_len_a: assert property (hold <= STRETCH)
    else $error("stretch too long");
  hold_cause_a: assert property ($rose(o_serial_hold_oe) |->
    $past(o_mode) == GPMC_MODE_DEEP || $past(o_mode, 2) == GPMC_MODE_DEEP)
    else $error("stretch outside deep idle exit");
  strobe_gap_a: assert property (o_measure_strobe && o_mode == mode_q |-> gap >= per - 3)
    else $error("strobe too early");
  strobe_due_a: assert property (gap <= per + 2)
    else $error("strobe overdue");
endmodule

bind gpmc_top gpmc_chk #(
  .NORMAL_PERIOD(NORMAL_PERIOD), .SLEEP_PERIOD(SLEEP_PERIOD),
  .DEEP_PERIOD(DEEP_PERIOD), .STRETCH(STRETCH)
) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_wake_current_threshold(i_wake_current_threshold),
  .i_serial_activity(i_serial_activity), .o_measure_strobe(o_measure_strobe),
  .o_calibrate(o_calibrate), .o_hf_osc_enable(o_hf_osc_enable), .o_mode(o_mode),
  .o_serial_hold_oe(o_serial_hold_oe)
);

// ===== test/gpmc_host.sv
// Host model on the serial side: makes bus activity, rides out stretching.
// Assumes the controller hold output is wired to i_hold_oe.
`timescale 1ns/1ns
module gpmc_host (
  // Clock and stretch sense
  input wire logic i_clk,
  input wire logic i_hold_oe,
  // Bus activity level
  output logic o_act
);
  initial o_act = 1'b0;
  // Burst of len cycles; count held cycles over the burst and the 80 cycles after it
  task automatic poke(input int len, output int held);
    int k;
    held = 0;
    @(posedge i_clk);
    o_act <= 1'b1;
    for (k = 0; k < len + 80; k++) begin
      @(posedge i_clk);
      if (i_hold_oe === 1'b1) held++;
      if (k == len - 1) o_act <= 1'b0;
    end
  endtask
endmodule

// ===== test/gpmc_top_tb.sv
// Self-checking bench for the power mode controller.
// Assumes shortened counts: periods 10/20/40, wait tick 5, stretch 20.
`timescale 1ns/1ns
module gpmc_top_tb;
  import gpmc_pkg::*;
  localparam int TICK = 5;
  localparam int STR = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdata;
  logic signed [15:0] cur = 16'sh7fff;
  logic signed [15:0] lim;
  logic wake = 1'b0;
  logic act, wreq, strobe, cal, osc, hold;
  logic [1:0] mode;
  logic [31:0] seed = 32'h0000_5b9c;
  logic [3:0] amap [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  logic [31:0] aexp [5] = '{32'h0, {16'h0000, IDLE_LIMIT_RESET}, 32'h0, 32'h0, 32'h0};
  int err_count = 0;
  int comparisons = 0;
  int n;
  int w;
  gpmc_top #(.CAL_CYCLES(CAL_CYCLES_DEF), .NORMAL_PERIOD(10), .SLEEP_PERIOD(20),
    .DEEP_PERIOD(40), .WAIT_TICK(TICK), .STRETCH(STR)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_average_current_value(cur), .i_wake_current_threshold(wake),
    .i_serial_activity(act), .o_measure_strobe(strobe), .o_calibrate(cal),
    .o_hf_osc_enable(osc), .o_mode(mode), .o_serial_hold_oe(hold));
  gpmc_host u_host (.i_clk(i_clk), .i_hold_oe(hold), .o_act(act));
  initial forever #10 i_clk = ~i_clk;
  //////////////////////////////
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic results();
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    rd <= !w_en;
    wr <= w_en;
    addr <= a;
    wd <= d;
    do begin
      @(posedge i_clk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin err_count++; results(); end
  endtask
  // Wait for mode (sel 0) or calibrate (sel 1) to reach v
  task automatic wait_for(input logic sel, input logic [1:0] v, input int bound);
    n = 0;
    while ((sel ? {1'b0, cal} : mode) !== v && n < bound) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= bound) begin err_count++; results(); end
  endtask
  //////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    foreach (amap[i]) begin
      bus(1'b0, amap[i], 32'h0);
      chk(q, aexp[i]);
    end
    seed = next_rand(seed);
    lim = {8'h0, seed[7:0]} + 16'h0010;
    bus(1'b1, ADDR_IDLE_LIMIT, {16'h0, lim});
    cur <= lim - 16'sh1;
    repeat (60) @(posedge i_clk);
    chk({cal, mode}, 3'h0);
    cur <= lim;
    bus(1'b1, ADDR_CONFIG, 32'h1);
    repeat (60) @(posedge i_clk);
    chk({cal, mode}, 3'h0);
    cur <= lim - 16'sh1;
    wait_for(1'b1, 2'h1, 100);
    repeat (4) @(posedge i_clk);
    cur <= lim;
    repeat (30) @(posedge i_clk);
    chk({cal, mode}, 3'h0);
    cur <= lim - 16'sh1;
    wait_for(1'b1, 2'h1, 100);
    wait_for(1'b1, 2'h0, 100);
    chk(n, CAL_CYCLES_DEF);
    wait_for(1'b0, GPMC_MODE_SLEEP, 4);
    cur <= lim;
    wait_for(1'b0, GPMC_MODE_NORMAL, 4);
    cur <= lim - 16'sh1;
    wait_for(1'b0, GPMC_MODE_SLEEP, 200);
    wake <= 1'b1;
    wait_for(1'b0, GPMC_MODE_NORMAL, 8);
    wake <= 1'b0;
    bus(1'b1, ADDR_COMMAND, 32'h1);
    bus(1'b0, ADDR_CONFIG, 32'h0);
    chk(q & 32'h3, 32'h3);
    wait_for(1'b0, GPMC_MODE_DEEP, 200);
    chk(osc, 1'b0);
    u_host.poke(6, w);
    chk(w, STR);
    bus(1'b0, ADDR_CONFIG, 32'h0);
    chk({osc, q[1:0]}, 3'h5);
    repeat (100) @(posedge i_clk);
    chk(mode, GPMC_MODE_SLEEP);
    seed = next_rand(seed);
    w = seed[1:0] % 3 + 1;
    bus(1'b1, ADDR_WAIT_TIME, w);
    cur <= lim;
    wait_for(1'b0, GPMC_MODE_NORMAL, 8);
    cur <= lim - 16'sh1;
    wait_for(1'b0, GPMC_MODE_SLEEP, 200);
    wait_for(1'b0, GPMC_MODE_DEEP, 200);
    chk(n >= w * TICK - 2 && n <= w * TICK + 2, 1'b1);
    results();
  end
endmodule
